// >>> core/slcs_chan_pick.sv
// Channel choice: preferred channel first, else lowest free secondary
`timescale 1ns/1ps
module slcs_chan_pick #(
  parameter int N  = 4,
  parameter int CW = 2
) (
  // Channel state
  input  wire logic [N-1:0]  busy,
  input  wire logic [N-1:0]  mask,
  input  wire logic [N-1:0]  avoid,
  input  wire logic [CW-1:0] pref,
  // Choice
  output logic               found,
  output logic      [CW-1:0] ch,
  output logic               prefOk
);
  logic [N-1:0] avail;

  for (genvar g = 0; g < N; g++) begin : gAvail
    assign avail[g] = mask[g] & ~busy[g] & ~avoid[g];
  end

  assign prefOk = avail[pref];

  // Same inputs give the same choice on every unit of a cluster
  always_comb begin
    ch    = pref;
    found = prefOk;
    if (!prefOk) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (avail[i]) begin
          ch    = CW'(i);
          found = 1'b1;
        end
      end
    end
  end
endmodule : slcs_chan_pick

// >>> core/slcs_pkg.sv
// Shared listen cycle scheduler constants, register map and state type
package slcs_pkg;
  localparam int CLK_MHZ        = 10;
  localparam int CNT_W          = 24;
  localparam int NCH            = 4;
  // Phase times in their own units and derived cycle counts
  localparam int T_CYCLE_MS     = 1000;
  localparam int T_REF_TOL_US   = 500;
  localparam int T_PRE_IDLE_US  = 1000;
  localparam int T_SCREEN_US    = 1500;
  localparam int T_LISTEN_US    = 5000;
  localparam int T_POST_IDLE_US = 500;
  localparam int T_MGMT_MS      = 20;
  localparam int T_PULSE_HI_MS  = 16;
  localparam int T_PULSE_LO_MS  = 4;
  localparam int T_OFF_MS       = 100;
  localparam int T_WIN_SHORT_MS = 500;
  localparam int T_WIN_LONG_MS  = 1000;
  localparam int CYCLE_N        = T_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int REF_TOL_N      = T_REF_TOL_US * CLK_MHZ;
  localparam int PRE_IDLE_N     = T_PRE_IDLE_US * CLK_MHZ;
  localparam int SCREEN_N       = T_SCREEN_US * CLK_MHZ;
  localparam int LISTEN_N       = T_LISTEN_US * CLK_MHZ;
  localparam int POST_IDLE_N    = T_POST_IDLE_US * CLK_MHZ;
  localparam int MGMT_N         = T_MGMT_MS * 1000 * CLK_MHZ;
  localparam int PULSE_HI_N     = T_PULSE_HI_MS * 1000 * CLK_MHZ;
  localparam int PULSE_LO_N     = T_PULSE_LO_MS * 1000 * CLK_MHZ;
  localparam int OFF_N          = T_OFF_MS * 1000 * CLK_MHZ;
  localparam int WIN_SHORT_N    = T_WIN_SHORT_MS * 1000 * CLK_MHZ;
  localparam int WIN_LONG_N     = T_WIN_LONG_MS * 1000 * CLK_MHZ;
  // Register map
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  STAT_OFF      = 8'h04;
  localparam int          CTRL_EN_B     = 0;
  localparam int          CTRL_INH_B    = 1;
  localparam int          CTRL_WIN_B    = 2;
  localparam int          CTRL_MST_B    = 3;
  localparam int          CTRL_PREF_LSB = 4;
  localparam int          CTRL_MASK_LSB = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0f00;
  localparam int          STAT_CH_LSB   = 8;
  localparam int          STAT_WON_B    = 10;
  localparam int          STAT_AINH_B   = 11;
  localparam int          STAT_SKIP_B   = 12;
  localparam int          STAT_OFF_B    = 13;
  localparam int          STAT_EXT_B    = 14;
  typedef enum logic [7:0] {
    ST_WAIT   = 8'h01,
    ST_PRE    = 8'h02,
    ST_SCREEN = 8'h04,
    ST_LISTEN = 8'h08,
    ST_POST   = 8'h10,
    ST_MGMT   = 8'h20,
    ST_TXWIN  = 8'h40,
    ST_SKIP   = 8'h80
  } slcs_state_t;
endpackage : slcs_pkg

// >>> core/slcs_sched.sv
// Shared listen cycle scheduler with APB register slave
// Function
// (R1) Cycle of 1000 ms, realigned to the common time reference tick.
// (R2) Idle 1000 us before the listen phase, transmitter off.
// (R3) Idle 500 us after the listen phase, transmitter off.
// (R4) Pre-screen 1500 us; its results steer the listen channel.
// (R5) Listen lasts exactly 5000 us, never extended randomly.
// (R6) Management slot of 20 ms holds a full pre-pulse.
// (R7) Pre-pulse is sent in the management slot.
// (R8) Only one master per channel sends a pre-pulse.
// (R9) Transmit window fixed at 0.5 s or 1 s by configuration; the cycle end cuts the 1 s window to 972 ms.
// (R10) Transmission starts at window start, stops when transaction ends.
// (R11) Without trigger the cycle still runs but transmitter stays off; a winning master still sends its pre-pulse without txReq.
// (R12) Cluster members pick channels by the same deterministic plan.
// (R13) Four assigned channels; preferred channel used when free.
// (R14) Extended transaction switches to another channel.
// (R15) No alternative channel forces a 100 ms transmitter-off period.
// (R16) Blocked from all but one channel: skip one whole cycle.
// (R17) Detected pre-pulse lets the unit occupy the channel, timing kept.
// (R18) One listen attempt per cycle, only in the common listen phase.
// (R19) Pre-screen at least two channels, always including the preferred.
// (R20) Pre-screen ends directly into the listen phase.
// (R21) Bad time reference or software can inhibit operation.
// (R22) Pre-pulse is 16 ms high power then 4 ms reduced power.
// (R23) Phases run pre-idle, screen, listen, post-idle, management, transmit.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module slcs_sched #(
  parameter int CYCLE_N     = slcs_pkg::CYCLE_N,
  parameter int REF_TOL_N   = slcs_pkg::REF_TOL_N,
  parameter int PRE_IDLE_N  = slcs_pkg::PRE_IDLE_N,
  parameter int SCREEN_N    = slcs_pkg::SCREEN_N,
  parameter int LISTEN_N    = slcs_pkg::LISTEN_N,
  parameter int POST_IDLE_N = slcs_pkg::POST_IDLE_N,
  parameter int MGMT_N      = slcs_pkg::MGMT_N,
  parameter int PULSE_HI_N  = slcs_pkg::PULSE_HI_N,
  parameter int PULSE_LO_N  = slcs_pkg::PULSE_LO_N,
  parameter int OFF_N       = slcs_pkg::OFF_N,
  parameter int WIN_SHORT_N = slcs_pkg::WIN_SHORT_N,
  parameter int WIN_LONG_N  = slcs_pkg::WIN_LONG_N
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Time reference
  input  wire logic        refTick,
  input  wire logic        refValid,
  // Radio status
  input  wire logic [3:0]  scrBusy,
  input  wire logic        lbtBusy,
  input  wire logic        prePulseSeen,
  input  wire logic        txReq,
  input  wire logic        txDone,
  // Radio control
  output logic             scrEn,
  output logic      [3:0]  scrMask,
  output logic             lbtEn,
  output logic             txEn,
  output logic             txHighPower,
  output logic      [1:0]  chSel,
  output logic      [7:0]  phase
);
  localparam int W = slcs_pkg::CNT_W;

  slcs_pkg::slcs_state_t st_r;
  slcs_pkg::slcs_state_t stNxt;

  logic [31:0]  ctrl_r;
  logic [31:0]  prdata_r;
  logic [W-1:0] cycCnt_r;
  logic [W-1:0] tmCnt;
  logic [W-1:0] tmVal;
  logic [W-1:0] offCnt;
  logic [1:0]   chSel_r;
  logic [3:0]   scrMask_r;
  logic [3:0]   scrRes_r;
  logic [3:0]   avoid;
  logic [3:0]   prefOh;
  logic [3:0]   nextOh;
  logic [1:0]   pickCh;
  logic         tmExp;
  logic         tmLoad;
  logic         offExp;
  logic         offStart;
  logic         offAct;
  logic         pickFound;
  logic         cycEnd;
  logic         cycStart;
  logic         refOk;
  logic         autoInh_r;
  logic         inhibited;
  logic         lbtSeen_r;
  logic         ppSeen_r;
  logic         won_r;
  logic         txGo_r;
  logic         ext_r;
  logic         skipPend_r;
  logic         pulseOwner;
  logic         inHi;
  logic         inPulse;
  logic         scrEn_r;
  logic         lbtEn_r;
  logic         txEn_r;
  logic         txHi_r;
  logic         txEnNxt;
  logic         leaveScr;
  logic         leaveLbt;
  logic         leaveTx;
  logic         enterTx;

  // Register bus decode, zero wait states
  logic       hitCtrl;
  logic       hitStat;
  logic       ctrlWr;
  logic       rdSetup;
  logic [31:0] statVal;
  logic [31:0] rdVal;

  assign hitCtrl = (paddr == slcs_pkg::CTRL_OFF);
  assign hitStat = (paddr == slcs_pkg::STAT_OFF);
  assign ctrlWr  = psel && penable && pwrite && hitCtrl;
  assign rdSetup = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hitCtrl || hitStat);
  assign statVal = {17'h0_0000, ext_r, offAct, skipPend_r, autoInh_r, won_r,
                    chSel_r, st_r};
  assign rdVal   = hitCtrl ? ctrl_r : (hitStat ? statVal : 32'h0000_0000);
  assign prdata  = prdata_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r   <= slcs_pkg::CTRL_RST;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (ctrlWr) ctrl_r <= pwdata & 32'h0000_0f3f;
      if (rdSetup) prdata_r <= rdVal;
    end
  end

  logic       ctrlEn;
  logic       ctrlInh;
  logic       ctrlWin;
  logic       ctrlMst;
  logic [1:0] ctrlPref;
  logic [3:0] ctrlMask;

  assign ctrlEn   = ctrl_r[slcs_pkg::CTRL_EN_B];
  assign ctrlInh  = ctrl_r[slcs_pkg::CTRL_INH_B];
  assign ctrlWin  = ctrl_r[slcs_pkg::CTRL_WIN_B];
  assign ctrlMst  = ctrl_r[slcs_pkg::CTRL_MST_B];
  assign ctrlPref = ctrl_r[slcs_pkg::CTRL_PREF_LSB +: 2];
  assign ctrlMask = ctrl_r[slcs_pkg::CTRL_MASK_LSB +: 4];

  // Cycle counter; reference tick restarts it
  assign cycEnd   = (cycCnt_r == W'(CYCLE_N - 1));
  assign cycStart = cycEnd || refTick; // R1
  // Tick must land within the cycle tolerance of the boundary
  assign refOk    = (cycCnt_r >= W'(CYCLE_N - 1 - REF_TOL_N)) ||
                    (cycCnt_r <= W'(REF_TOL_N));
  assign inhibited = ctrlInh || autoInh_r || !ctrlEn; // R21

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cycCnt_r  <= '0;
      autoInh_r <= 1'b1;
    end else begin
      cycCnt_r <= cycStart ? '0 : cycCnt_r + {{(W-1){1'b0}}, 1'b1}; // R1
      if (!refValid || (refTick && !refOk)) autoInh_r <= 1'b1; // R21
      else if (refTick) autoInh_r <= 1'b0;
    end
  end

  // Phase sequencing
  always_comb begin
    stNxt = st_r;
    if (cycStart) begin
      stNxt = !ctrlEn ? slcs_pkg::ST_WAIT :
              (skipPend_r ? slcs_pkg::ST_SKIP : slcs_pkg::ST_PRE); // R16
    end else begin
      unique case (st_r)
        slcs_pkg::ST_WAIT:   stNxt = slcs_pkg::ST_WAIT;
        slcs_pkg::ST_PRE:    if (tmExp) stNxt = slcs_pkg::ST_SCREEN; // R23
        slcs_pkg::ST_SCREEN: if (tmExp) stNxt = slcs_pkg::ST_LISTEN; // R20
        slcs_pkg::ST_LISTEN: if (tmExp) stNxt = slcs_pkg::ST_POST; // R18
        slcs_pkg::ST_POST:   if (tmExp) stNxt = slcs_pkg::ST_MGMT; // R23
        slcs_pkg::ST_MGMT:   if (tmExp) stNxt = slcs_pkg::ST_TXWIN; // R23
        slcs_pkg::ST_TXWIN:  if (tmExp) stNxt = slcs_pkg::ST_WAIT; // R9
        slcs_pkg::ST_SKIP:   stNxt = slcs_pkg::ST_SKIP;
      endcase
    end
  end

  // Each phase length loads on entry
  assign tmLoad = (stNxt != st_r) || cycStart;
  assign tmVal  = (stNxt == slcs_pkg::ST_PRE)    ? W'(PRE_IDLE_N) :   // R2
                  (stNxt == slcs_pkg::ST_SCREEN) ? W'(SCREEN_N) :     // R4
                  (stNxt == slcs_pkg::ST_LISTEN) ? W'(LISTEN_N) :     // R5
                  (stNxt == slcs_pkg::ST_POST)   ? W'(POST_IDLE_N) :  // R3
                  (stNxt == slcs_pkg::ST_MGMT)   ? W'(MGMT_N) :       // R6
                  (ctrlWin ? W'(WIN_LONG_N) : W'(WIN_SHORT_N));       // R9

  slcs_timer #(.W(W)) uPhase (
    .clk_sys (clk_sys),
    .srst    (srst),
    .load    (tmLoad),
    .loadVal (tmVal),
    .cnt     (tmCnt),
    .expire  (tmExp)
  );

  slcs_timer #(.W(W)) uOff (
    .clk_sys (clk_sys),
    .srst    (srst),
    .load    (offStart),
    .loadVal (W'(OFF_N)),
    .cnt     (offCnt),
    .expire  (offExp)
  );

  assign offAct = (offCnt != '0) || offExp; // R15

  // Channel choice, switching away after an overrun
  assign prefOh = 4'h1 << ctrlPref;
  assign nextOh = 4'h1 << (ctrlPref + 2'h1);
  assign avoid  = ext_r ? (4'h1 << chSel_r) : 4'h0; // R14

  slcs_chan_pick #(.N(slcs_pkg::NCH), .CW(2)) uPick (
    .busy   (scrRes_r),
    .mask   (ctrlMask),
    .avoid  (avoid),
    .pref   (ctrlPref),
    .found  (pickFound),
    .ch     (pickCh),
    .prefOk ()
  );

  assign leaveScr = (st_r == slcs_pkg::ST_SCREEN) && (stNxt == slcs_pkg::ST_LISTEN);
  assign leaveLbt = (st_r == slcs_pkg::ST_LISTEN) && (stNxt != slcs_pkg::ST_LISTEN);
  assign enterTx  = (st_r != slcs_pkg::ST_TXWIN) && (stNxt == slcs_pkg::ST_TXWIN);
  assign leaveTx  = (st_r == slcs_pkg::ST_TXWIN) && (stNxt != slcs_pkg::ST_TXWIN);
  assign offStart = leaveScr && ext_r && !pickFound; // R15

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r       <= slcs_pkg::ST_WAIT;
      chSel_r    <= 2'h0;
      scrRes_r   <= 4'h0;
      lbtSeen_r  <= 1'b0;
      ppSeen_r   <= 1'b0;
      won_r      <= 1'b0;
      txGo_r     <= 1'b0;
      ext_r      <= 1'b0;
      skipPend_r <= 1'b0;
    end else begin
      st_r <= stNxt;
      if (st_r == slcs_pkg::ST_SCREEN) scrRes_r <= scrBusy & scrMask_r; // R4
      if (leaveScr && pickFound) chSel_r <= pickCh; // R13 R12
      if (leaveScr) lbtSeen_r <= 1'b0;
      // Listener output is meaningless until its enable has gone out
      else if (st_r == slcs_pkg::ST_LISTEN && lbtEn_r && lbtBusy) lbtSeen_r <= 1'b1; // R18
      if (prePulseSeen) ppSeen_r <= 1'b1;
      else if (cycStart) ppSeen_r <= 1'b0;
      if (cycStart) won_r <= 1'b0;
      else if (leaveLbt) won_r <= (pickFound && !lbtSeen_r && !lbtBusy &&
                                   !offAct) || ppSeen_r; // R17
      // Foreign pre-pulse only shows up in the slot, after listening
      else if (ppSeen_r) won_r <= 1'b1; // R17
      // Start only at window entry; a late trigger waits for next cycle
      if (enterTx) txGo_r <= won_r && txReq && !inhibited && !offAct; // R10 R11
      else if (txDone || leaveTx || cycStart) txGo_r <= 1'b0; // R10
      // Window cut by the cycle end is a leaveTx too; held through the next screen until the next leaveTx
      if (leaveTx) ext_r <= txGo_r && !txDone && txReq; // R14
      if (offStart) skipPend_r <= 1'b1; // R16
      else if (cycStart && skipPend_r) skipPend_r <= 1'b0;
    end
  end

  // Pre-pulse shape from the remaining slot count
  assign pulseOwner = ctrlMst && won_r && !ppSeen_r; // R8
  assign inHi    = tmCnt >= W'(MGMT_N - PULSE_HI_N); // R22
  assign inPulse = tmCnt >= W'(MGMT_N - PULSE_HI_N - PULSE_LO_N); // R22
  assign txEnNxt = !inhibited && !offAct &&
                   (((st_r == slcs_pkg::ST_MGMT) && pulseOwner && inPulse) || // R7
                    ((st_r == slcs_pkg::ST_TXWIN) && txGo_r && !txDone)); // R10

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scrEn_r   <= 1'b0;
      scrMask_r <= 4'h0;
      lbtEn_r   <= 1'b0;
      txEn_r    <= 1'b0;
      txHi_r    <= 1'b0;
    end else begin
      scrEn_r   <= (st_r == slcs_pkg::ST_SCREEN);
      scrMask_r <= ctrlMask | prefOh | nextOh; // R19
      lbtEn_r   <= (st_r == slcs_pkg::ST_LISTEN); // R18
      txEn_r    <= txEnNxt;
      txHi_r    <= txEnNxt && ((st_r != slcs_pkg::ST_MGMT) || inHi); // R22
    end
  end

  assign scrEn       = scrEn_r;
  assign scrMask     = scrMask_r;
  assign lbtEn       = lbtEn_r;
  assign txEn        = txEn_r;
  assign txHighPower = txHi_r;
  assign chSel       = chSel_r;
  assign phase       = st_r;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic [W-1:0] dwell_r;
  logic         cut;

  assign cut = cycStart;

  always_ff @(posedge clk_sys) begin
    if (srst || tmLoad) dwell_r <= '0;
    else dwell_r <= dwell_r + {{(W-1){1'b0}}, 1'b1};
  end

  chk_pre_idle_len: assert property ( // R2
    (st_r == slcs_pkg::ST_PRE && stNxt != st_r && !cut) |-> dwell_r == W'(PRE_IDLE_N - 1)
  ) else $error("pre idle length wrong");
  chk_screen_len: assert property ( // R4
    (st_r == slcs_pkg::ST_SCREEN && stNxt != st_r && !cut) |-> dwell_r == W'(SCREEN_N - 1)
  ) else $error("screen length wrong");
  chk_listen_len: assert property ( // R5
    (st_r == slcs_pkg::ST_LISTEN && stNxt != st_r && !cut) |-> dwell_r == W'(LISTEN_N - 1)
  ) else $error("listen length wrong");
  chk_post_idle_len: assert property ( // R3
    (st_r == slcs_pkg::ST_POST && stNxt != st_r && !cut) |-> dwell_r == W'(POST_IDLE_N - 1)
  ) else $error("post idle length wrong");
  chk_screen_to_listen: assert property ( // R20
    (st_r == slcs_pkg::ST_SCREEN && stNxt != st_r && !cut) |=> st_r == slcs_pkg::ST_LISTEN
  ) else $error("screen not followed by listen");
  chk_tx_phase_only: assert property ( // R11
    txEn |-> $past(st_r) == slcs_pkg::ST_MGMT || $past(st_r) == slcs_pkg::ST_TXWIN
  ) else $error("transmit outside slot or window");
  chk_inhibit_quiet: assert property ( // R21
    $past(inhibited) |-> !txEn
  ) else $error("transmit while inhibited");
  chk_pulse_high_pow: assert property ( // R22
    (txEn && $past(st_r) == slcs_pkg::ST_MGMT && st_r == slcs_pkg::ST_MGMT &&
     !txHighPower) |=> !txHighPower
  ) else $error("pre-pulse returned to high power");
  chk_skip_entry: assert property ( // R16
    (skipPend_r && cycStart && ctrlEn) |=> st_r == slcs_pkg::ST_SKIP ##1 !lbtEn
  ) else $error("skip cycle not taken");
  chk_tx_on_done: assert property ( // R10
    (st_r == slcs_pkg::ST_TXWIN && txDone) |=> !txEn
  ) else $error("transmit after done");

  cov_tx_window: cover property (enterTx && won_r && txReq);
  cov_pre_pulse: cover property (txEn && txHighPower && st_r == slcs_pkg::ST_MGMT);
  cov_skip: cover property (st_r == slcs_pkg::ST_SKIP);
  cov_switch: cover property (leaveScr && ext_r && pickFound);
endmodule : slcs_sched

// >>> core/slcs_timer.sv
// Load-and-expire down counter for phase and off-period timing
`timescale 1ns/1ps
module slcs_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  // State
  output logic      [W-1:0] cnt,
  output logic              expire
);
  logic [W-1:0] cnt_r;
  logic         act_r;

  // Expires after exactly loadVal cycles
  assign expire = act_r && (cnt_r == '0);
  assign cnt    = cnt_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r <= '0;
      act_r <= 1'b0;
    end else if (load) begin
      cnt_r <= loadVal - {{(W-1){1'b0}}, 1'b1};
      act_r <= 1'b1;
    end else if (expire) begin
      act_r <= 1'b0;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule : slcs_timer

// >>> sim/slcs_peer.sv
// Far-side interrogators: shared time reference, occupancy and foreign pre-pulse
`timescale 1ns/1ps
module slcs_peer #(
  parameter int PER = 2000,
  parameter int PP  = 53
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Plan from the bench
  input  wire logic       tickOn,
  input  wire logic [3:0] busyPlan,
  input  wire logic       lbtPlan,
  input  wire logic       pulseOn,
  // Scheduler side
  input  wire logic       scrEn,
  input  wire logic       lbtEn,
  output logic            refTick,
  output logic [3:0]      scrBusy,
  output logic            lbtBusy,
  output logic            prePulseSeen
);
  int         cnt   = 0;
  logic [3:0] churn = 4'h3;

  always_ff @(posedge clk_sys) begin
    churn <= churn + 4'h5;
    if (srst || !tickOn || cnt == PER - 1) cnt <= 0;
    else cnt <= cnt + 1;
  end

  // One common tick for the whole cluster
  assign refTick      = tickOn && cnt == 0;
  // Unscreened lines churn so stale values never look valid
  assign scrBusy      = scrEn ? busyPlan : churn;
  assign lbtBusy      = lbtEn ? lbtPlan : churn[0];
  // A single foreign master pulses inside the management slot
  assign prePulseSeen = pulseOn && cnt >= PP && cnt < PP + 16;
endmodule : slcs_peer

// >>> sim/slcs_sched_tb.sv
// Self-checking bench for the shared listen cycle scheduler
`timescale 1ns/1ps
module slcs_sched_tb;
  localparam int PI = 10, SC = 15, LI = 20, PO = 5, MG = 40, HI = 32, LO = 8;
  localparam int OF = 600, WSH = 500, WLO = 1000, CY = 2000, TOL = 20;
  localparam int MS = PI + SC + LI + PO, WS = MS + MG, LIMIT = 50000;
  localparam logic [7:0] PRE = slcs_pkg::ST_PRE, SCR = slcs_pkg::ST_SCREEN;
  localparam logic [7:0] LIS = slcs_pkg::ST_LISTEN, WT = slcs_pkg::ST_WAIT;
  localparam logic [7:0] SKP = slcs_pkg::ST_SKIP;
  localparam logic [7:0] CT = slcs_pkg::CTRL_OFF, ST = slcs_pkg::STAT_OFF;

  logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, phase;
  logic [31:0] pwdata, prdata;
  logic        refTick, refValid, lbtBusy, prePulseSeen, txReq, txDone;
  logic [3:0]  scrBusy, scrMask, busyPlan;
  logic        scrEn, lbtEn, txEn, txHighPower, tickOn, lbtPlan, pulseOn;
  logic [1:0]  chSel;
  int          miscompares = 0, n_tests = 0, cyc = 0, seed = 32'h70ef;

  slcs_sched #(.CYCLE_N(CY), .REF_TOL_N(TOL), .PRE_IDLE_N(PI), .SCREEN_N(SC),
    .LISTEN_N(LI), .POST_IDLE_N(PO), .MGMT_N(MG), .PULSE_HI_N(HI), .PULSE_LO_N(LO),
    .OFF_N(OF), .WIN_SHORT_N(WSH), .WIN_LONG_N(WLO)) DUT (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refTick(refTick), .refValid(refValid), .scrBusy(scrBusy),
    .lbtBusy(lbtBusy), .prePulseSeen(prePulseSeen), .txReq(txReq), .txDone(txDone),
    .scrEn(scrEn), .scrMask(scrMask), .lbtEn(lbtEn), .txEn(txEn),
    .txHighPower(txHighPower), .chSel(chSel), .phase(phase));

  slcs_peer #(.PER(CY), .PP(MS + 3)) peer (
    .clk_sys(clk_sys), .srst(srst), .tickOn(tickOn), .busyPlan(busyPlan),
    .lbtPlan(lbtPlan), .pulseOn(pulseOn), .scrEn(scrEn), .lbtEn(lbtEn),
    .refTick(refTick), .scrBusy(scrBusy), .lbtBusy(lbtBusy),
    .prePulseSeen(prePulseSeen));

  always #50 clk_sys = ~clk_sys;

  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic waitPh(input logic [7:0] ph, output int n);
    n = 0;
    while (phase !== ph && n < 3 * CY) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : waitPh

  // Model: phase expected k samples after the pre-idle phase appears
  function automatic logic [7:0] expPh(input int k, input int w);
    if (k < 0 || k >= WS + w) return WT;
    if (k < PI) return PRE;
    if (k < PI + SC) return SCR;
    if (k < PI + SC + LI) return LIS;
    if (k < MS) return slcs_pkg::ST_POST;
    if (k < WS) return slcs_pkg::ST_MGMT;
    return slcs_pkg::ST_TXWIN;
  endfunction : expPh

  // Model: preferred channel first, else lowest free one
  function automatic int pick(input logic [3:0] b, input int p, input int av);
    if (!b[p] && p != av) return p;
    for (int i = 0; i < 4; i++) if (!b[i] && i != av) return i;
    return -1;
  endfunction : pick

  // Outputs lag the phase by one sample; txDone lands d samples into the window
  task automatic runCycle(input int w, input logic pul, input int d, input int ch,
                          input logic [3:0] sm);
    int   n;
    logic et;
    waitPh(PRE, n);
    for (int k = 0; k < WS + w; k++) begin
      check(phase, expPh(k, w));
      check(lbtEn, expPh(k - 1, w) == LIS);
      check(scrEn, expPh(k - 1, w) == SCR);
      et = (pul && k > MS && k <= WS) || (k > WS && k <= WS + d);
      check(txEn, et);
      if (pul && k > MS && k <= WS) check(txHighPower, k <= MS + HI);
      if (k == WS + 1 && ch >= 0) check(chSel, ch);
      if (k == PI + 5) check(scrMask, sm);
      if (d > 0 && d < w && k == WS + d - 1) begin
        txDone <= 1'b1;
        txReq <= 1'b0;
      end
      if (k == WS + d) txDone <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : runCycle

  initial begin
    int          n, n2, w, d, c;
    logic [31:0] q;
    logic        e, l, mst, inh, wl, won, own;
    logic [1:0]  pp;
    logic [3:0]  b, m, sm;
    clk_sys = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {refValid, txReq, txDone, tickOn, lbtPlan, pulseOn, busyPlan} = 10'h200;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    apb(1'b0, CT, 32'h0, q, e);
    check(q, slcs_pkg::CTRL_RST);
    apb(1'b0, ST, 32'h0, q, e);
    check(q[11:0], 12'h801);
    apb(1'b1, ST, 32'hffff_ffff, q, e);
    check(e, 1'b0);
    apb(1'b0, 8'h08, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    apb(1'b1, CT, 32'hffff_ffff, q, e);
    apb(1'b0, CT, 32'h0, q, e);
    check(q, 32'h0000_0f3f);
    apb(1'b1, CT, 32'h0000_0f01, q, e);
    // Free running cycle, then realign to the shared tick
    waitPh(PRE, n);
    waitPh(SCR, n);
    waitPh(PRE, n2);
    check(n + n2, CY);
    repeat (($random(seed) & 511) + 3) @(posedge clk_sys);
    tickOn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(phase, PRE);
    waitPh(SCR, n);
    waitPh(PRE, n);
    apb(1'b0, ST, 32'h0, q, e);
    check(q[11], 1'b0);
    waitPh(WT, n);
    // Random channel plans; 1 all masked, 2 inhibit, 3 long window, 4 idle, 6 foreign
    for (int i = 0; i < 7; i++) begin
      pp = 2'($random(seed));
      b = (i == 1 || i == 6) ? 4'h0 : 4'($random(seed));
      l = (i == 6) || (($random(seed) & 3) == 0);
      mst = (i % 2 == 1) || (i == 6);
      inh = (i == 2);
      wl = (i == 3);
      m = (i == 1) ? 4'h0 : 4'hf;
      w = wl ? WLO : WSH;
      c = pick(b | ~m, pp, -1);
      won = (c >= 0) && !inh && (!l || i == 6);
      own = won && mst && !l;
      d = (won && i != 4) ? 5 + ($random(seed) & 255) : 0;
      sm = m | (4'h1 << pp) | (4'h1 << (pp + 2'd1));
      busyPlan <= b;
      lbtPlan <= l;
      pulseOn <= (i == 6);
      txReq <= (i != 4);
      apb(1'b1, CT, {20'h0, m, 2'b00, pp, mst, wl, inh, 1'b1}, q, e);
      runCycle(w, own, d, d > 0 ? c : -1, sm);
    end
    // Overrun with a free alternative switches channel, no off period
    pulseOn <= 1'b0;
    busyPlan <= 4'h0;
    lbtPlan <= 1'b0;
    txReq <= 1'b1;
    apb(1'b1, CT, 32'h0000_0f11, q, e);
    runCycle(WSH, 1'b0, WSH, 1, 4'hf);
    apb(1'b0, ST, 32'h0, q, e);
    check(q[14:13], 2'b10);
    runCycle(WSH, 1'b0, 40, pick(4'h0, 1, 1), 4'hf);
    // Overrun with only one channel open: off period, then one skipped cycle
    busyPlan <= 4'hd;
    txReq <= 1'b1;
    runCycle(WSH, 1'b0, WSH, 1, 4'hf);
    // Off period starts only once the next screen finds no way out
    waitPh(slcs_pkg::ST_POST, n);
    apb(1'b0, ST, 32'h0, q, e);
    check(q[14:12], 3'b111);
    waitPh(SKP, n);
    n = 0;
    d = 0;
    while (phase === SKP && n < CY + 10) begin
      n++;
      if (txEn === 1'b1) d++;
      @(posedge clk_sys);
    end
    check(n, CY);
    check(d, 0);
    check(phase, PRE);
    txReq <= 1'b0;
    refValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, ST, 32'h0, q, e);
    check(q[11], 1'b1);
    wrap_up();
  end
endmodule : slcs_sched_tb
